//--- tb/arb_model.sv
// bus arbiter model granting ownership for a fixed span
`timescale 1ns/1ps
`default_nettype none
module arb_model #(
  parameter int HOLD = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bus_request,
  input wire logic allow,
  output logic bus_grant
);
  int left_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_grant <= 1'b0;
      left_q <= 0;
    end else if (bus_grant) begin
      left_q <= left_q - 1;
      if (left_q == 1) bus_grant <= 1'b0;
    end else if (bus_request && allow) begin
      bus_grant <= 1'b1;
      left_q <= HOLD;
    end
  end
endmodule : arb_model
`default_nettype wire

//--- tb/dma_wait_checker.sv
// port assertions for the wait/stall block
`timescale 1ns/1ps
`default_nettype none
module dma_wait_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dma_wait_pkg::axil_req_t axi_req,
  input wire dma_wait_pkg::axil_rsp_t axi_rsp,
  input wire logic bus_grant,
  input wire logic xfer_pending,
  input wire logic bus_request,
  input wire logic stall_detected,
  input wire logic irq
);
  // ************
  // properties
  // ************
  // cycles without bus ownership, saturating
  logic [7:0] ng_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) ng_q <= 8'h00;
    else if (bus_grant) ng_q <= 8'h00;
    else if (ng_q != 8'hff) ng_q <= ng_q + 8'h01;
  end
  AST_REQ_CAUSE: assert property (bus_request |-> $past(xfer_pending && !bus_grant))
    else $error("request without cause");
  AST_STALL_WAIT: assert property ($rose(stall_detected) |-> ng_q >= 8'h3c)
    else $error("stall flagged too early");
  AST_STALL_CLR: assert property ($fell(stall_detected) |-> axi_rsp.bvalid || !axi_rsp.awready)
    else $error("stall cleared without write");
  AST_B_LAT: assert property ($rose(axi_rsp.bvalid) |-> $past(!axi_rsp.awready && !axi_rsp.wready))
    else $error("write answered early");
  AST_B_REFUSE: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken during answer");
  AST_R_LAT: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read not answered");
  AST_R_REFUSE: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken during answer");
  AST_R_DROP: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid && axi_rsp.arready)
    else $error("read answer not retired");
endmodule : dma_wait_checker
bind dma_channel_wait_stall_status dma_wait_checker u_chk (.clk_sys(clk_sys), .rst(rst),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .bus_grant(bus_grant), .xfer_pending(xfer_pending),
  .bus_request(bus_request), .stall_detected(stall_detected), .irq(irq));
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the wait/stall block
`include "dma_wait_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [1:0] rs;
    logic [7:0] ra;
    logic [31:0] m;
    logic [31:0] e;
  } row_t;
  localparam row_t ROWS [5] = '{
    '{`OFS_STATUS_HI, 32'hffff_ffff, `RESP_OKAY, `OFS_STATUS_HI, 32'hffff_ffff, 32'h0},
    '{`OFS_CONTROL, 32'h2, `RESP_OKAY, `OFS_STATUS_LO, 32'h0000_ffff, 32'h400},
    '{`OFS_STATUS_LO, 32'hffff_fdff, `RESP_OKAY, `OFS_STATUS_LO, 32'hffff_ffff, 32'h400},
    '{`OFS_CONTROL, 32'h0, `RESP_OKAY, `OFS_STATUS_LO, 32'hffff_ffff, 32'h0},
    '{8'h40, 32'h1, `RESP_SLVERR, 8'h44, 32'hffff_ffff, 32'h0}};
  // ************
  // harness
  // ************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic pend = 1'b0;
  logic allow = 1'b0;
  logic bus_grant, bus_request, stall_detected, irq, b, ar, w;
  logic [7:0] sl = `OFS_STATUS_LO;
  dma_wait_pkg::axil_req_t req = '0;
  dma_wait_pkg::axil_rsp_t rsp;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int tw, tr, t0, t1, n;
  logic [31:0] d, d1;
  logic [1:0] r;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  dma_channel_wait_stall_status DUT (.clk_sys(clk_sys), .rst(rst), .axi_req(req),
    .axi_rsp(rsp), .bus_grant(bus_grant), .xfer_pending(pend), .bus_request(bus_request),
    .stall_detected(stall_detected), .irq(irq));
  arb_model arb (.clk_sys(clk_sys), .rst(rst), .bus_request(bus_request), .allow(allow),
    .bus_grant(bus_grant));
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input int lim);
    if (n == lim) num_errors++;
    if (n == lim) end_sim();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk_sys);
      ar = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      @(posedge clk_sys);
      if (ar) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) break;
    end
    req.bready <= 1'b0;
    tmo(64);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk_sys);
      ar = rsp.arready;
      b = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      if (ar) tr = cyc;
      @(posedge clk_sys);
      if (ar) req.arvalid <= 1'b0;
      if (b) break;
    end
    req.rready <= 1'b0;
    tmo(64);
  endtask : rd
  task automatic wt(input int s, input logic v);
    logic [2:0] x;
    for (n = 0; n < 1000; n++) begin
      @(negedge clk_sys);
      x = {stall_detected, bus_request, bus_grant};
      if (x[s] === v) break;
    end
    tw = cyc;
    tmo(1000);
  endtask : wt
  task automatic own(input logic [31:0] v);
    wr(`OFS_CONTROL, v);
    @(posedge clk_sys) allow <= 1'b1;
    wt(0, 1'b1);
    @(posedge clk_sys) allow <= 1'b0;
    wt(0, 1'b0);
    t0 = tw;
    rd(sl);
    d1 = d;
    t1 = tr;
  endtask : own
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(sl);
    chk(d, 32'h0);
    chk({stall_detected, irq, bus_request}, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wr(ROWS[i].wa, ROWS[i].wd);
      chk(r, ROWS[i].rs);
      rd(ROWS[i].ra);
      chk(r, ROWS[i].rs);
      chk(d & ROWS[i].m, ROWS[i].e);
    end
    $display("register test done");
    wr(`OFS_REQUEST_DELAY, 32'h64);
    @(posedge clk_sys) pend <= 1'b1;
    own(32'h0);
    repeat (10) @(posedge clk_sys);
    rd(sl);
    chk(d1[31:16] - d[31:16], tr - t1);
    chk(d1[31:16] <= 16'h64, 1'b1);
    wt(1, 1'b1);
    chk(tw - t0 >= 100 && tw - t0 <= 105, 1'b1);
    rd(sl);
    chk(d[31:16], 32'h0);
    chk(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h2);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h2);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    $display("memory mode test done");
    wr(`OFS_STALL_INTERVAL, 32'h100);
    own(32'h1);
    repeat (64) @(posedge clk_sys);
    rd(sl);
    chk(d1[31:16] - d[31:16] - (tr - t1) / 64 <= 1, 1'b1);
    wt(2, 1'b1);
    chk(tw - t0 >= 256 && tw - t0 <= 260, 1'b1);
    rd(sl);
    chk(d[31:16], 32'h4);
    chk(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    repeat (100) @(posedge clk_sys);
    rd(sl);
    chk(d[31:16], 32'h4);
    wr(sl, 32'h0);
    @(negedge clk_sys);
    chk(stall_detected, 1'b1);
    wr(sl, 32'h200);
    @(negedge clk_sys);
    chk(stall_detected, 1'b0);
    repeat (70) @(posedge clk_sys);
    rd(sl);
    chk(d[31:16] > 16'h1 && d[31:16] < 16'h4, 1'b1);
    $display("io mode test done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

//--- verilog/dma_channel_wait_stall_status.sv
// channel wait counter, stall detection and status register behind an axi4-lite slave
`include "dma_wait_map.svh"
`timescale 1ns/1ps
`default_nettype none

module dma_channel_wait_stall_status #(
  parameter int WAIT_W = 16,
  parameter int DELAY_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire dma_wait_pkg::axil_req_t axi_req,
  output var dma_wait_pkg::axil_rsp_t axi_rsp,
  input wire logic bus_grant,
  input wire logic xfer_pending,
  output logic bus_request,
  output logic stall_detected,
  output logic irq
);

  // ************************************************************
  // parameter check
  // ************************************************************
  if (WAIT_W != 16 || DELAY_W < 1 || DELAY_W > WAIT_W) begin : g_bad_param
    $error("wait counter must be 16 bits and delay no wider");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    dma_wait_pkg::axil_rsp_t rsp;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    dma_wait_pkg::wait_state_t st;
    logic [WAIT_W-1:0] wait_cnt;
    logic [5:0] div;
    logic grant_prev;
    logic ext_req;
    logic chain_en;
    logic stall_flag;
    logic [31:0] stall_interval;
    logic [DELAY_W-1:0] req_delay;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic bus_request;
    logic irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    logic ok;
    if (a == `OFS_STATUS_LO) begin
      ok = 1'b1;
    end else if (a == `OFS_STATUS_HI) begin
      ok = 1'b1;
    end else if (a == `OFS_CONTROL) begin
      ok = 1'b1;
    end else if (a == `OFS_STALL_INTERVAL) begin
      ok = 1'b1;
    end else if (a == `OFS_REQUEST_DELAY) begin
      ok = 1'b1;
    end else if (a == `OFS_IRQ_STATUS) begin
      ok = 1'b1;
    end else if (a == `OFS_IRQ_MASK) begin
      ok = 1'b1;
    end else begin
      ok = 1'b0;
    end
    return ok;
  endfunction : mapped

  localparam logic [5:0] TICK_LAST = 6'(`WAIT_TICK_CYCLES - 1);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic do_write;
    logic [31:0] wv;
    logic [31:0] rd;
    logic release_ev;
    logic tick;
    logic stall_set;
    logic stall_clr;
    logic delay_set;
    logic [1:0] irq_clr;
    logic [WAIT_W-1:0] io_load;
    logic [WAIT_W-1:0] mem_load;
    do_write = 1'b0;
    wv = 32'h0000_0000;
    rd = 32'h0000_0000;
    release_ev = 1'b0;
    tick = 1'b0;
    stall_set = 1'b0;
    stall_clr = 1'b0;
    delay_set = 1'b0;
    irq_clr = 2'b00;
    io_load = s_q.stall_interval[`WAIT_TICK_SHIFT +: WAIT_W];
    mem_load = WAIT_W'(s_q.req_delay);
    s_d = s_q;

    // write address and data, taken in either order
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid) begin
      do_write = 1'b1;
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = mapped(s_q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    s_d.rsp.awready = !s_d.aw_held && !s_d.rsp.bvalid;
    s_d.rsp.wready = !s_d.w_held && !s_d.rsp.bvalid;

    // register writes
    if (do_write) begin
      wv = merge(32'h0000_0000, s_q.w_data, s_q.w_strb);
      if (s_q.aw_addr == `OFS_STATUS_LO) begin
        stall_clr = wv[`BIT_STALL_FLAG];
      end else if (s_q.aw_addr == `OFS_CONTROL) begin
        wv = merge({30'h0, s_q.chain_en, s_q.ext_req}, s_q.w_data, s_q.w_strb);
        s_d.ext_req = wv[`BIT_CTRL_EXT_REQ];
        s_d.chain_en = wv[`BIT_CTRL_CHAIN];
      end else if (s_q.aw_addr == `OFS_STALL_INTERVAL) begin
        s_d.stall_interval = merge(s_q.stall_interval, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == `OFS_REQUEST_DELAY) begin
        wv = merge(32'(s_q.req_delay), s_q.w_data, s_q.w_strb);
        s_d.req_delay = wv[DELAY_W-1:0];
      end else if (s_q.aw_addr == `OFS_IRQ_STATUS) begin
        irq_clr = wv[1:0];
      end else if (s_q.aw_addr == `OFS_IRQ_MASK) begin
        wv = merge({30'h0, s_q.irq_mask}, s_q.w_data, s_q.w_strb);
        s_d.irq_mask = wv[1:0];
      end
    end

    // 64-cycle tick for the i/o mode count
    if (s_q.ext_req) begin
      s_d.div = s_q.div + 6'h01;
      tick = (s_q.div == TICK_LAST);
    end else begin
      s_d.div = 6'h00;
    end

    // ownership tracking and wait counter
    release_ev = s_q.grant_prev && !bus_grant;
    s_d.grant_prev = bus_grant;
    case (s_q.st)
      dma_wait_pkg::WAIT_OWN: begin
        if (release_ev) begin
          s_d.st = dma_wait_pkg::WAIT_COUNT;
          s_d.div = 6'h00;
          s_d.wait_cnt = s_q.ext_req ? io_load : mem_load;
        end
      end
      dma_wait_pkg::WAIT_COUNT: begin
        if (bus_grant) begin
          s_d.st = dma_wait_pkg::WAIT_OWN;
        end else if (s_q.ext_req) begin
          if (tick) begin
            if (s_q.wait_cnt <= WAIT_W'(1)) begin
              stall_set = 1'b1;
              s_d.wait_cnt = io_load;
              s_d.st = dma_wait_pkg::WAIT_HALT;
            end else begin
              s_d.wait_cnt = s_q.wait_cnt - WAIT_W'(1);
            end
          end
        end else if (s_q.wait_cnt == '0) begin
          delay_set = 1'b1;
          s_d.st = dma_wait_pkg::WAIT_HALT;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt - WAIT_W'(1);
        end
      end
      dma_wait_pkg::WAIT_HALT: begin
        if (bus_grant) begin
          s_d.st = dma_wait_pkg::WAIT_OWN;
        end else if (s_q.ext_req && stall_clr) begin
          s_d.st = dma_wait_pkg::WAIT_COUNT;
          s_d.div = 6'h00;
        end
      end
      default: begin
        s_d.st = dma_wait_pkg::WAIT_OWN;
      end
    endcase

    // sticky flags, a set in the same cycle beats the clear
    s_d.stall_flag = stall_set || (s_q.stall_flag && !stall_clr);
    s_d.irq_status[`BIT_IRQ_STALL] = stall_set ||
                                     (s_q.irq_status[`BIT_IRQ_STALL] && !irq_clr[`BIT_IRQ_STALL]);
    s_d.irq_status[`BIT_IRQ_DELAY] = delay_set ||
                                     (s_q.irq_status[`BIT_IRQ_DELAY] && !irq_clr[`BIT_IRQ_DELAY]);
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);

    // memory mode holds the request back while the delay runs
    s_d.bus_request = xfer_pending && !bus_grant &&
                      (s_d.ext_req || s_d.st != dma_wait_pkg::WAIT_COUNT);

    // reads
    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_q.rsp.arready) begin
      if (axi_req.araddr == `OFS_STATUS_LO) begin
        rd[`BIT_WAIT_LO +: WAIT_W] = s_q.wait_cnt;
        rd[`BIT_CHAIN_MIRROR] = s_q.chain_en;
        rd[`BIT_STALL_FLAG] = s_q.stall_flag;
      end else if (axi_req.araddr == `OFS_STATUS_HI) begin
        rd = 32'h0000_0000;
      end else if (axi_req.araddr == `OFS_CONTROL) begin
        rd[`BIT_CTRL_EXT_REQ] = s_q.ext_req;
        rd[`BIT_CTRL_CHAIN] = s_q.chain_en;
      end else if (axi_req.araddr == `OFS_STALL_INTERVAL) begin
        rd = s_q.stall_interval;
      end else if (axi_req.araddr == `OFS_REQUEST_DELAY) begin
        rd[DELAY_W-1:0] = s_q.req_delay;
      end else if (axi_req.araddr == `OFS_IRQ_STATUS) begin
        rd[1:0] = s_q.irq_status;
      end else if (axi_req.araddr == `OFS_IRQ_MASK) begin
        rd[1:0] = s_q.irq_mask;
      end
      s_d.rsp.rdata = rd;
      s_d.rsp.rresp = mapped(axi_req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
      s_d.rsp.rvalid = 1'b1;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= dma_wait_pkg::WAIT_OWN;
      s_q.wait_cnt <= `RST_WAIT_COUNTER;
      s_q.stall_interval <= `RST_STALL_INTERVAL;
      s_q.req_delay <= DELAY_W'(`RST_REQUEST_DELAY);
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready <= 1'b1;
      s_q.rsp.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign axi_rsp = s_q.rsp;
  assign bus_request = s_q.bus_request;
  assign stall_detected = s_q.stall_flag;
  assign irq = s_q.irq;

endmodule : dma_channel_wait_stall_status

`default_nettype wire

//--- verilog/dma_wait_map.svh
// register offsets, field positions, reset values and timing counts of the wait/stall block
`ifndef DMA_WAIT_MAP_SVH
`define DMA_WAIT_MAP_SVH

`define OFS_STATUS_LO 8'h00
`define OFS_STATUS_HI 8'h04
`define OFS_CONTROL 8'h08
`define OFS_STALL_INTERVAL 8'h0c
`define OFS_REQUEST_DELAY 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18

`define BIT_WAIT_LO 16
`define BIT_CHAIN_MIRROR 10
`define BIT_STALL_FLAG 9
`define BIT_CTRL_EXT_REQ 0
`define BIT_CTRL_CHAIN 1
`define BIT_IRQ_STALL 0
`define BIT_IRQ_DELAY 1

`define RST_WAIT_COUNTER 16'h0000
`define RST_STALL_INTERVAL 32'h0000_0000
`define RST_REQUEST_DELAY 16'h0000

`define WAIT_TICK_CYCLES 64
`define WAIT_TICK_SHIFT 6

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- verilog/dma_wait_pkg.sv
// types shared by the wait/stall block: bus carriers and counter states
package dma_wait_pkg;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  typedef enum logic [2:0] {
    WAIT_OWN = 3'b001,
    WAIT_COUNT = 3'b010,
    WAIT_HALT = 3'b100
  } wait_state_t;

endpackage : dma_wait_pkg
